// ### rfc_pkg.sv
// constants, field layouts and carriers of the receive framer control bank
package rfc_pkg;
  localparam logic [8:0] IDX_HDLC_CTRL = 9'h010;
  localparam logic [8:0] IDX_SUPPRESS = 9'h011;
  localparam logic [8:0] IDX_MON_SEL = 9'h012;
  localparam logic [8:0] IDX_SIG_CTRL = 9'h013;
  localparam logic [8:0] IDX_T1_CTRL2 = 9'h014;
  localparam logic [8:0] IDX_MON_DATA = 9'h018;
  localparam logic [8:0] IDX_LIVE = 9'h019;
  localparam logic [8:0] IDX_IRQ_STAT = 9'h01A;
  localparam logic [8:0] IDX_IRQ_MASK = 9'h01B;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] MON_SEL_MASK = 8'h1F;
  localparam logic [7:0] SIG_CTRL_MASK = 8'h17;
  localparam logic [7:0] T1_CTRL2_MASK = 8'h1F;
  localparam int HC_CRC = 7;
  localparam int HC_RST = 6;
  localparam int HC_MAP = 5;
  localparam int SC_FORCE1 = 4;
  localparam int SC_FFRZ = 2;
  localparam int SC_FEN = 1;
  localparam int SC_INTEG = 0;
  localparam int T2_SLC = 4;
  localparam int T2_OOF_LO = 2;
  localparam int T2_RAI = 1;
  localparam int EV_RAI = 0;
  localparam int EV_SIG = 1;
  localparam int EV_CAS = 2;
  localparam int EV_HRST = 3;
  localparam logic [2:0] FL_2OF4 = 3'h4;
  localparam logic [2:0] FL_2OF5 = 3'h5;
  localparam logic [2:0] FL_2OF6 = 3'h6;
  localparam logic [1:0] SIG_STABLE_MF = 2'h3;
  localparam logic [15:0] RAI_PAT = 16'h00FF;
  localparam logic [4:0] RAI_CLR_MAX = 5'h0E;
  localparam int RAI_MS = 200;
  localparam int CLK_MHZ = 200;
  localparam int RAI_CYC = RAI_MS * 1000 * CLK_MHZ;
  localparam int TMR_W = 26;

  typedef struct packed {
    logic frame_tick;
    logic mf_tick;
    logic e1_mode;
    logic esf_mode;
    logic chan_valid;
    logic [4:0] chan_num;
    logic [7:0] chan_data;
    logic [3:0] sig_bits;
    logic freeze_req;
    logic mfas_err;
    logic ts16_zero;
    logic fdl_valid;
    logic [15:0] fdl_word;
  } rfc_port_in_t;

  typedef struct packed {
    logic hdlc_reset;
    logic crc_display;
    logic map_fdl;
    logic [4:0] hdlc_chan;
    logic [7:0] bit_enable;
    logic force_ones;
    logic sig_freeze;
    logic cas_alt;
    logic cas_resync;
    logic slc96_en;
    logic [2:0] oof_window;
    logic rai;
    logic [3:0] sig_state;
    logic [7:0] chan_monitor;
  } rfc_port_ctl_t;
endpackage : rfc_pkg

// ### rfc_bank.sv
// receive framer control bank: apb registers and per-port receive control
//
// Contract
// R1 - crc display bit makes hdlc append received crc-16 after last octet
// R2 - hdlc reset flushes controller, device clears bit within two frames
// R3 - map select 0 feeds hdlc from ds0, 1 from fdl or sa bits
// R4 - five-bit channel select picks ds0 for hdlc, zero is channel 1
// R5 - new channel select applies only after an hdlc reset completes
// R6 - each suppress bit removes its bit position from hdlc reception
// R7 - monitor select field picks ds0 shown in monitor data register
// R8 - t1 force-ones bit forces robbed-bit signaling ones per flagged channel
// R9 - e1 cas resync after two consecutive errored multiframe alignment signals
// R10 - alternate criteria also resync on multiframe with ts16 all zero
// R11 - force freeze freezes signaling output regardless of freeze enable
// R12 - freeze enable permits freezing; zero means no freezing
// R13 - integration off reports changes at once, on after three stable multiframes
// R14 - t1 control bit enables loop-carrier superframe synchronizer
// R15 - out-of-frame select codes 2/4, 2/5, 2/6 framing bits in error
// R16 - rai set after 16 consecutive 00ff, cleared at 14 or fewer of 16
// R17 - rai integration sets and clears only after persisting over 200ms
// R18 - hdlc control at index 010h, ports repeated at stride 200h
// R19 - one bank per port, all bits reset zero, reserved bits read zero
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rfc_bank
  import rfc_pkg::*;
#(
  parameter int NPORTS = 8,
  parameter int RAI_HOLD_CYC = RAI_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire rfc_port_in_t [NPORTS-1:0] port_in,
  output rfc_port_ctl_t [NPORTS-1:0] port_ctl
);

  typedef struct packed {
    logic [7:0] hc;
    logic [7:0] bs;
    logic [7:0] ms;
    logic [7:0] sc;
    logic [7:0] t2;
    logic [4:0] chan_act;
    logic [7:0] mon;
    logic cas_err;
    logic [3:0] sig_rep;
    logic [3:0] sig_cand;
    logic [1:0] sig_cnt;
    logic [15:0] rai_win;
    logic rai_raw;
    logic rai;
    logic [TMR_W-1:0] rai_tmr;
    logic [3:0] st;
    logic [3:0] mk;
    rfc_port_ctl_t o;
  } rfc_pst_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    rfc_pst_t [NPORTS-1:0] p;
  } rfc_state_t;

  if (NPORTS < 1 || NPORTS > 8) begin : g_chk_ports
    $error("port count must be 1 to 8");
  end
  if (RAI_HOLD_CYC < 1 || RAI_HOLD_CYC >= (1 << TMR_W)) begin : g_chk_tmr
    $error("rai hold count does not fit its timer");
  end

  localparam logic [TMR_W-1:0] RAI_HOLD = TMR_W'(RAI_HOLD_CYC);

  rfc_state_t q;
  rfc_state_t n;

  logic [2:0] pidx;
  logic [8:0] off;
  logic hit;
  logic wr_now;

  assign pidx = paddr[13:11];
  assign off = paddr[10:2];
  assign hit = ({1'b0, pidx} < 4'(NPORTS));
  assign wr_now = psel && penable && q.pready && pwrite && pstrb[0];

  always_comb begin
    rfc_pst_t c;
    rfc_port_in_t pi;
    logic sel;
    logic [3:0] ev;
    logic [4:0] ones;
    logic frz;
    logic resync;
    logic [7:0] rd;
    logic ok;
    c = '0;
    pi = '0;
    sel = 1'b0;
    ev = 4'h0;
    ones = 5'h00;
    frz = 1'b0;
    resync = 1'b0;
    rd = 8'h00;
    ok = 1'b0;
    n = q;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.irq = 1'b0;
    // apb read decode, one wait state
    if (psel && penable && !q.pready) begin
      n.pready = 1'b1;
      if (hit) begin
        c = q.p[pidx];
        ok = 1'b1;
        unique case (off)
          IDX_HDLC_CTRL: rd = c.hc; // see R18
          IDX_SUPPRESS: rd = c.bs;
          IDX_MON_SEL: rd = c.ms;
          IDX_SIG_CTRL: rd = c.sc;
          IDX_T1_CTRL2: rd = c.t2;
          IDX_MON_DATA: rd = c.mon; // see R7
          IDX_LIVE: rd = {c.sig_rep, 3'h0, c.rai};
          IDX_IRQ_STAT: rd = {4'h0, c.st};
          IDX_IRQ_MASK: rd = {4'h0, c.mk};
          default: ok = 1'b0;
        endcase
      end
      n.prdata = {24'h00_0000, ok ? rd : 8'h00}; // see R19
      n.pslverr = !ok;
    end
    for (int i = 0; i < NPORTS; i++) begin
      c = q.p[i];
      pi = port_in[i];
      ev = 4'h0;
      resync = 1'b0;
      sel = wr_now && hit && (pidx == 3'(i));
      // acknowledged hdlc reset, completes on next frame
      if (c.hc[HC_RST] && pi.frame_tick) begin
        c.hc[HC_RST] = 1'b0; // see R2
        c.chan_act = c.hc[4:0]; // see R5
        ev[EV_HRST] = 1'b1;
      end
      // channel monitor capture
      if (pi.chan_valid && pi.chan_num == c.ms[4:0]) begin
        c.mon = pi.chan_data; // see R7
      end
      // cas multiframe resync
      if (pi.mf_tick && pi.e1_mode) begin
        if (pi.mfas_err) begin
          resync = c.cas_err; // see R9
          c.cas_err = !c.cas_err;
        end else begin
          c.cas_err = 1'b0;
        end
        if (c.sc[SC_FORCE1] && pi.ts16_zero) begin
          resync = 1'b1; // see R10
          c.cas_err = 1'b0;
        end
      end
      ev[EV_CAS] = resync;
      // signaling freeze
      frz = c.sc[SC_FFRZ] || (c.sc[SC_FEN] && pi.freeze_req); // see R11 see R12
      // signaling change of state
      if (pi.mf_tick) begin
        if (pi.sig_bits != c.sig_cand) begin
          c.sig_cand = pi.sig_bits;
          c.sig_cnt = 2'h1;
        end else if (c.sig_cnt != SIG_STABLE_MF) begin
          c.sig_cnt = c.sig_cnt + 2'h1;
        end
        if (!frz) begin
          if (!c.sc[SC_INTEG] && pi.sig_bits != c.sig_rep) begin
            c.sig_rep = pi.sig_bits; // see R13
            ev[EV_SIG] = 1'b1;
          end else if (c.sc[SC_INTEG] && c.sig_cnt == SIG_STABLE_MF
                       && c.sig_cand != c.sig_rep) begin
            c.sig_rep = c.sig_cand; // see R13
            ev[EV_SIG] = 1'b1;
          end
        end
      end
      // esf rai detector over last 16 patterns
      if (!pi.esf_mode) begin
        c.rai_win = 16'h0000;
        c.rai_raw = 1'b0;
      end else if (pi.fdl_valid) begin
        c.rai_win = {c.rai_win[14:0], pi.fdl_word == RAI_PAT};
        ones = 5'($countones(c.rai_win));
        if (&c.rai_win) begin
          c.rai_raw = 1'b1; // see R16
        end else if (ones <= RAI_CLR_MAX) begin
          c.rai_raw = 1'b0; // see R16
        end
      end
      // rai integration timer
      if (!c.t2[T2_RAI]) begin
        c.rai_tmr = '0;
        if (c.rai != c.rai_raw) begin
          c.rai = c.rai_raw;
          ev[EV_RAI] = 1'b1;
        end
      end else if (c.rai == c.rai_raw) begin
        c.rai_tmr = '0;
      end else if (c.rai_tmr == RAI_HOLD) begin
        c.rai = c.rai_raw; // see R17
        c.rai_tmr = '0;
        ev[EV_RAI] = 1'b1;
      end else begin
        c.rai_tmr = c.rai_tmr + TMR_W'(1);
      end
      // sticky status, set wins over clear
      if (sel && off == IDX_IRQ_STAT) begin
        c.st = c.st & ~pwdata[3:0];
      end
      c.st = c.st | ev;
      // register writes, after hardware updates
      if (sel) begin
        unique case (off)
          IDX_HDLC_CTRL: c.hc = pwdata[7:0];
          IDX_SUPPRESS: c.bs = pwdata[7:0];
          IDX_MON_SEL: c.ms = pwdata[7:0] & MON_SEL_MASK; // see R19
          IDX_SIG_CTRL: c.sc = pwdata[7:0] & SIG_CTRL_MASK;
          IDX_T1_CTRL2: c.t2 = pwdata[7:0] & T1_CTRL2_MASK;
          IDX_IRQ_MASK: c.mk = pwdata[3:0];
          default: c.mk = c.mk;
        endcase
      end
      // registered control outputs
      c.o.hdlc_reset = c.hc[HC_RST]; // see R2
      c.o.crc_display = c.hc[HC_CRC]; // see R1
      c.o.map_fdl = c.hc[HC_MAP]; // see R3
      c.o.hdlc_chan = c.chan_act; // see R4
      c.o.bit_enable = ~c.bs; // see R6
      c.o.force_ones = c.sc[SC_FORCE1] && !pi.e1_mode; // see R8
      c.o.sig_freeze = frz;
      c.o.cas_alt = c.sc[SC_FORCE1] && pi.e1_mode; // see R10
      c.o.cas_resync = resync;
      c.o.slc96_en = c.t2[T2_SLC] && !pi.e1_mode; // see R14
      unique case (c.t2[T2_OOF_LO+:2])
        2'h0: c.o.oof_window = FL_2OF4; // see R15
        2'h1: c.o.oof_window = FL_2OF5;
        default: c.o.oof_window = FL_2OF6;
      endcase
      c.o.rai = c.rai;
      c.o.sig_state = c.sig_rep;
      c.o.chan_monitor = c.mon;
      n.irq = n.irq || (|(c.st & c.mk));
      n.p[i] = c;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0; // see R19
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  for (genvar g = 0; g < NPORTS; g++) begin : g_port
    assign port_ctl[g] = q.p[g].o;

    a_hdlc_rst_done: assert property (q.p[g].hc[HC_RST] && port_in[g].frame_tick // see R2
        |=> q.p[g].st[EV_HRST] && (!port_ctl[g].hdlc_reset || $past(wr_now)))
      else $error("hdlc reset did not complete on frame");

    a_chan_latch: assert property (q.p[g].hc[HC_RST] && port_in[g].frame_tick // see R5
        |=> port_ctl[g].hdlc_chan == $past(q.p[g].hc[4:0]))
      else $error("hdlc channel not taken at reset completion");

    a_chan_hold: assert property (!($past(q.p[g].hc[HC_RST]) // see R5
        && $past(port_in[g].frame_tick)) |-> $stable(port_ctl[g].hdlc_chan))
      else $error("hdlc channel changed without reset");

    a_monitor_cap: assert property (port_in[g].chan_valid // see R7
        && port_in[g].chan_num == q.p[g].ms[4:0]
        |=> port_ctl[g].chan_monitor == $past(port_in[g].chan_data))
      else $error("monitor data not captured");

    a_cas_two_err: assert property (port_in[g].e1_mode && port_in[g].mf_tick // see R9
        && port_in[g].mfas_err && q.p[g].cas_err |=> port_ctl[g].cas_resync)
      else $error("no resync after two errored alignments");

    a_cas_zero_ts: assert property (port_in[g].e1_mode && port_in[g].mf_tick // see R10
        && port_in[g].ts16_zero && q.p[g].sc[SC_FORCE1] |=> port_ctl[g].cas_resync)
      else $error("no resync on all zero signaling slot");

    a_freeze_force: assert property (q.p[g].sc[SC_FFRZ] |=> port_ctl[g].sig_freeze) // see R11
      else $error("force freeze not applied");

    a_freeze_hold: assert property (port_in[g].mf_tick && q.p[g].sc[SC_FFRZ] // see R11
        |=> $stable(port_ctl[g].sig_state))
      else $error("signaling changed while frozen");

    a_freeze_none: assert property (!q.p[g].sc[SC_FFRZ] && !q.p[g].sc[SC_FEN] // see R12
        |=> !port_ctl[g].sig_freeze)
      else $error("freeze without enable");

    a_sig_direct: assert property (port_in[g].mf_tick && !q.p[g].sc[SC_INTEG] // see R13
        && !q.p[g].sc[SC_FFRZ] && !(q.p[g].sc[SC_FEN] && port_in[g].freeze_req)
        |=> port_ctl[g].sig_state == $past(port_in[g].sig_bits))
      else $error("signaling change not reported at once");

    a_force_t1_only: assert property (port_ctl[g].force_ones // see R8
        |-> !$past(port_in[g].e1_mode))
      else $error("force ones outside t1 mode");

    a_oof_code: assert property (q.p[g].t2[T2_OOF_LO+:2] == 2'h1 // see R15
        |-> port_ctl[g].oof_window == FL_2OF5)
      else $error("out of frame window wrong");

    a_oof_six: assert property (q.p[g].t2[T2_OOF_LO+1] // see R15
        |-> port_ctl[g].oof_window == FL_2OF6)
      else $error("out of frame window not six");

    a_rai_detect: assert property (port_in[g].esf_mode && port_in[g].fdl_valid // see R16
        && port_in[g].fdl_word == RAI_PAT && (&q.p[g].rai_win[14:0])
        && !q.p[g].t2[T2_RAI] |=> port_ctl[g].rai)
      else $error("rai not declared after 16 patterns");

    a_rai_integ: assert property ($past(q.p[g].t2[T2_RAI]) // see R17
        && port_ctl[g].rai != $past(port_ctl[g].rai) |-> $past(q.p[g].rai_tmr) == RAI_HOLD)
      else $error("rai changed before hold time");
  end

endmodule : rfc_bank
`default_nettype wire

// ### rfc_host.sv
// apb host model that carries register transfers to the bank
`timescale 1ns/1ps
`default_nettype none
module rfc_host (
  input wire logic mclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [13:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
  end

  // setup, then access held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : rfc_host
`default_nettype wire

// ### test_receive_framer_control_bank.sv
// self-checking bench of the receive framer control bank
`timescale 1ns/1ps
`default_nettype none
module test_receive_framer_control_bank;
  import rfc_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  wire logic psel, penable, pwrite, pready, pslverr, irq;
  wire logic [13:0] paddr;
  wire logic [31:0] pwdata, prdata;
  wire logic [3:0] pstrb;
  rfc_port_in_t [1:0] pin = '0;
  rfc_port_ctl_t [1:0] pc;
  int miscompares = 0;
  int total_checks = 0;
  int resyncs = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] v;
  logic [7:0] dv [5];
  logic [7:0] mk [5] = '{8'hBF, 8'hFF, MON_SEL_MASK, SIG_CTRL_MASK, T1_CTRL2_MASK};

  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (pc[0].cas_resync === 1'b1) resyncs++;

  rfc_bank #(.NPORTS(2), .RAI_HOLD_CYC(20)) rfc_bank_i (.mclk(mclk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .port_in(pin), .port_ctl(pc));
  rfc_host rfc_host_i (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));

  task stop_test;
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask : step

  task automatic look(input int n);
    step(n);
    #1;
  endtask : look

  function automatic logic [13:0] ad(input logic [8:0] i, input logic [2:0] p = 3'h0);
    return {p, i, 2'b00};
  endfunction : ad

  function automatic logic [2:0] frame_loss_select(input logic [1:0] c);
    return c == 2'b00 ? FL_2OF4 : (c == 2'b01 ? FL_2OF5 : FL_2OF6);
  endfunction : frame_loss_select

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    rfc_host_i.xfer(1'b1, a, {24'h00_0000, d}, rd, er);
  endtask : wr

  task automatic rdc(input logic [13:0] a, input logic [7:0] e);
    rfc_host_i.xfer(1'b0, a, 32'h0000_0000, rd, er);
    chk(rd, {24'h00_0000, e});
  endtask : rdc

  task automatic mf(input logic [3:0] s, input logic e, input logic z);
    step(1);
    pin[0].mf_tick <= 1'b1;
    pin[0].sig_bits <= s;
    pin[0].mfas_err <= e;
    pin[0].ts16_zero <= z;
    step(1);
    pin[0].mf_tick <= 1'b0;
  endtask : mf

  task automatic chan(input logic [4:0] n, input logic [7:0] d);
    step(1);
    pin[0].chan_valid <= 1'b1;
    pin[0].chan_num <= n;
    pin[0].chan_data <= d;
    step(1);
    pin[0].chan_valid <= 1'b0;
  endtask : chan

  task automatic fdl(input logic [15:0] w);
    step(1);
    pin[0].fdl_valid <= 1'b1;
    pin[0].fdl_word <= w;
    step(1);
    pin[0].fdl_valid <= 1'b0;
  endtask : fdl

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    stop_test();
  end

  initial begin
    v = 8'($urandom(54425));
    step(12);
    reset_n <= 1'b1;
    for (int i = 16; i < 28; i++) begin
      rdc(ad(9'(i)), 8'h00);
      chk(er, i > 20 && i < 24);
    end
    for (int k = 0; k < 12; k++) begin
      step(1);
      pin[0].freeze_req <= 1'($urandom);
      for (int j = 0; j < 5; j++) begin
        v = (k == 0 ? 8'hFF : 8'($urandom)) & (j == 0 ? 8'hBF : 8'hFF);
        wr(ad(9'(16 + j)), v);
        dv[j] = v & mk[j];
      end
      for (int j = 0; j < 5; j++) rdc(ad(9'(16 + j)), dv[j]);
      look(1);
      chk(pc[0].crc_display, dv[0][7]);
      chk(pc[0].map_fdl, dv[0][5]);
      chk(pc[0].hdlc_chan, 5'h00);
      chk(pc[0].bit_enable, 8'(~dv[1]));
      chk(pc[0].force_ones, dv[3][4]);
      chk(pc[0].sig_freeze, dv[3][2] | (dv[3][1] & pin[0].freeze_req));
      chk(pc[0].slc96_en, dv[4][4]);
      chk(pc[0].oof_window, frame_loss_select(dv[4][3:2]));
    end
    wr(ad(IDX_MON_SEL, 3'h1), 8'h15);
    rdc(ad(IDX_MON_SEL, 3'h1), 8'h15);
    rdc(ad(IDX_MON_SEL), dv[2]);
    rdc(ad(IDX_HDLC_CTRL, 3'h2), 8'h00);
    chk(er, 1'b1);
    wr(ad(IDX_MON_SEL), 8'h1F);
    chan(5'h1F, v);
    chan(5'h1E, ~v);
    look(2);
    chk(pc[0].chan_monitor, v);
    rdc(ad(IDX_MON_DATA), v);
    pin[0].e1_mode <= 1'b1;
    wr(ad(IDX_SIG_CTRL), 8'h00);
    mf(4'h5, 1'b1, 1'b0);
    mf(4'h5, 1'b1, 1'b0);
    look(2);
    chk(resyncs, 1);
    chk(pc[0].sig_state, 4'h5);
    mf(4'h5, 1'b1, 1'b0);
    mf(4'h5, 1'b0, 1'b0);
    mf(4'h5, 1'b1, 1'b0);
    mf(4'h5, 1'b0, 1'b1);
    look(2);
    chk(resyncs, 1);
    wr(ad(IDX_SIG_CTRL), 8'h10);
    mf(4'h5, 1'b0, 1'b1);
    look(2);
    chk(resyncs, 2);
    chk(pc[0].force_ones, 1'b0);
    chk(pc[0].cas_alt, 1'b1);
    wr(ad(IDX_SIG_CTRL), 8'h11);
    mf(4'hA, 1'b0, 1'b0);
    mf(4'hA, 1'b0, 1'b0);
    look(2);
    chk(pc[0].sig_state, 4'h5);
    mf(4'hA, 1'b0, 1'b0);
    look(2);
    chk(pc[0].sig_state, 4'hA);
    wr(ad(IDX_SIG_CTRL), 8'h04);
    mf(4'h3, 1'b0, 1'b0);
    look(2);
    chk(pc[0].sig_state, 4'hA);
    v = 8'($urandom) & 8'h1F;
    wr(ad(IDX_HDLC_CTRL), v | 8'h40);
    look(2);
    chk(pc[0].hdlc_chan, 5'h00);
    chk(pc[0].hdlc_reset, 1'b1);
    step(1);
    pin[0].frame_tick <= 1'b1;
    step(1);
    pin[0].frame_tick <= 1'b0;
    look(3);
    chk(pc[0].hdlc_chan, v[4:0]);
    chk(pc[0].hdlc_reset, 1'b0);
    chk(irq, 1'b0);
    rdc(ad(IDX_HDLC_CTRL), v);
    wr(ad(IDX_IRQ_MASK), 8'h08);
    look(2);
    chk(irq, 1'b1);
    rdc(ad(IDX_IRQ_STAT), 8'h0E);
    wr(ad(IDX_IRQ_STAT), 8'h08);
    look(2);
    chk(irq, 1'b0);
    step(1);
    pin[0].e1_mode <= 1'b0;
    pin[0].esf_mode <= 1'b1;
    wr(ad(IDX_T1_CTRL2), 8'h00);
    wr(ad(IDX_IRQ_MASK), 8'h01);
    repeat (15) fdl(RAI_PAT);
    look(4);
    chk(pc[0].rai, 1'b0);
    fdl(RAI_PAT);
    look(4);
    chk(pc[0].rai, 1'b1);
    chk(irq, 1'b1);
    fdl(16'($urandom) | 16'h0100);
    look(4);
    chk(pc[0].rai, 1'b1);
    fdl(16'($urandom) | 16'h0100);
    look(4);
    chk(pc[0].rai, 1'b0);
    wr(ad(IDX_T1_CTRL2), 8'h02);
    repeat (16) fdl(RAI_PAT);
    look(5);
    chk(pc[0].rai, 1'b0);
    look(30);
    chk(pc[0].rai, 1'b1);
    stop_test();
  end
endmodule : test_receive_framer_control_bank
`default_nettype wire
